/* File: ptm_checker.sv */
// port assertions for the periodic timer
`timescale 1ns/1ps
`default_nettype none
module ptm_checker #(
	parameter CW = 10
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// controls
	input wire logic [1:0] i_mode_select,
	input wire logic [1:0] i_pin_action,
	input wire logic i_output_control,
	input wire logic i_output_polarity,
	input wire logic i_clear_select,
	input wire logic [CW-1:0] i_duty_compare_value,
	input wire logic [CW-1:0] i_period_compare_value,
	// status and pin
	input wire logic o_run_control,
	input wire logic [CW-1:0] o_count,
	input wire logic o_duty_match_flag,
	input wire logic o_period_match_flag,
	input wire logic o_pin_out,
	input wire logic o_pin_out_en_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// pin level that a run start or an active phase should give
	wire logic act = i_output_control ^ i_output_polarity;
	sequence s_start;
		$rose(o_run_control);
	endsequence
	// pwm running for two edges, so the pin already follows the count
	sequence s_steady;
		o_run_control && $past(o_run_control) && i_mode_select == 2'h2;
	endsequence
	a_run_zero: assert property (s_start |-> o_count == 0)
		else $error("count not zero at run start");
	a_stop_hold: assert property (!o_run_control && !$past(o_run_control) |-> $stable(o_count))
		else $error("count moved while stopped");
	a_pin_release: assert property (i_mode_select == 2'h3 |=> o_pin_out_en_n)
		else $error("pin driven in timer mode");
	a_duty_zero: assert property ($rose(o_duty_match_flag) |-> $past(i_duty_compare_value) != 0)
		else $error("duty flag with zero duty value");
	a_duty_hit: assert property ($rose(o_duty_match_flag) && !i_clear_select
		&& $past(i_duty_compare_value) != $past(i_period_compare_value) |-> o_count == $past(i_duty_compare_value))
		else $error("duty flag away from duty value");
	a_no_pflag: assert property ($rose(o_period_match_flag) && i_mode_select == 2'h0 |-> !$past(i_clear_select))
		else $error("period flag with duty clear");
	a_pflag_wrap: assert property ($rose(o_period_match_flag) |-> o_count == 0)
		else $error("period flag without wrap");
	a_pulse_nop: assert property ($past(i_mode_select) == 2'h2 && $past(i_pin_action) == 2'h3
		|-> !$rose(o_period_match_flag)) else $error("period flag in pulse mode");
	a_pulse_end: assert property ($rose(o_duty_match_flag) && i_mode_select == 2'h2 && i_pin_action == 2'h3
		|-> !o_run_control && o_pin_out != act) else $error("pulse not ended on duty match");
	a_run_pin: assert property (s_start |-> i_mode_select != 2'h0 || o_pin_out == act)
		else $error("pin not at initial level");
	a_pwm_level: assert property (s_steady ##0 i_pin_action == 2'h2
		|-> o_pin_out == (((o_count < i_duty_compare_value) ~^ i_output_control) ^ i_output_polarity))
		else $error("pwm level wrong");
	a_pwm_force: assert property (s_steady ##0 !i_pin_action[1]
		|-> o_pin_out == ((i_pin_action[0] ~^ i_output_control) ^ i_output_polarity)) else $error("forced level wrong");
endmodule
bind ptm_top ptm_checker #(.CW(CW)) u_chk (.i_clk, .i_rst, .i_mode_select, .i_pin_action, .i_output_control,
	.i_output_polarity, .i_clear_select, .i_duty_compare_value, .i_period_compare_value, .o_run_control, .o_count,
	.o_duty_match_flag,
	.o_period_match_flag, .o_pin_out, .o_pin_out_en_n);
`default_nettype wire

/* File: ptm_cmp.v */
// equality comparator of the periodic timer
`timescale 1ns/1ps
`default_nettype none
module ptm_cmp #(
	parameter W = 10
) (
	// qualifier and operands
	input wire i_en,
	input wire i_zero_ok,
	input wire [W-1:0] i_count,
	input wire [W-1:0] i_value,
	// match pulse
	output wire o_hit
);
	// a zero compare value only matches when the caller allows it
	assign o_hit = i_en & (i_count == i_value) & (i_zero_ok | (|i_value)); // R22
endmodule
`default_nettype wire

/* File: ptm_map.vh */
// constants of the periodic timer mode logic
// Behaviour
// (R1) mode bits pick compare, timer, PWM/pulse
// (R2) clear-select low: period match or overflow clears
// (R3) clear-select high: duty match clears, duty flag only
// (R4) duty value zero: overflow at 3ff, no flag
// (R5) compare mode pin moves on duty match only
// (R6) pin action: none, low, high or toggle
// (R7) run rise loads pin with initial level
// (R8) timer mode counts like compare, pin released
// (R9) software sets mode 10, action 10 for PWM
// (R10) PWM clears on period match, ignores clear-select
// (R11) period equals value, zero means 1024 counts
// (R12) duty at or above period gives full active
// (R13) PWM raises duty and period flags
// (R14) PWM level, action and polarity control output
// (R15) forced PWM level keeps counting internally
// (R16) software sets mode 10, action 11 for pulse
// (R17) run rise or trigger edge starts pulse
// (R18) duty match or software clear ends pulse
// (R19) pulse counter resets only on run rise
// (R20) software never programs duty zero in compare
// (R21) run rise zeroes counter, stop keeps count
// (R22) match when counter equals compare value
`ifndef PTM_MAP_VH
`define PTM_MAP_VH

`define PTM_CW 10
`define PTM_CNT_ZERO 10'h000
`define PTM_CNT_ONE 10'h001
`define PTM_CNT_MAX 10'h3ff

`define PTM_MODE_CMP 2'h0
`define PTM_MODE_CAP 2'h1
`define PTM_MODE_PWM 2'h2
`define PTM_MODE_TMR 2'h3

`define PTM_ACT_NONE 2'h0
`define PTM_ACT_LOW 2'h1
`define PTM_ACT_HIGH 2'h2
`define PTM_ACT_TOGGLE 2'h3

`define PTM_PWM_INACTIVE 2'h0
`define PTM_PWM_ACTIVE 2'h1
`define PTM_PWM_OUTPUT 2'h2
`define PTM_PWM_SINGLE 2'h3

`define PTM_ST_STOP 2'h1
`define PTM_ST_RUN 2'h2

`endif

/* File: ptm_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ptm_sync #(
	parameter W = 1
) (
	// clock and reset
	input wire i_clk,
	input wire i_rst,
	// asynchronous level in, synchronised level out
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	// first stage is read only by the second stage
	always @(posedge i_clk) begin
		if (i_rst) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;
endmodule
`default_nettype wire

/* File: ptm_top.v */
// periodic timer: compare, timer, PWM and single pulse modes
`timescale 1ns/1ps
`default_nettype none
`include "ptm_map.vh"
module ptm_top #(
	parameter CW = `PTM_CW
) (
	// clock and reset
	input wire i_clk,
	input wire i_rst,
	// mode and pin control bits
	input wire [1:0] i_mode_select,
	input wire [1:0] i_pin_action,
	input wire i_output_control,
	input wire i_output_polarity,
	input wire i_clear_select,
	input wire i_count_pause,
	// run control write strobe
	input wire i_run_write,
	input wire i_run_wdata,
	// compare values
	input wire [CW-1:0] i_duty_compare_value,
	input wire [CW-1:0] i_period_compare_value,
	// external trigger pin and its active edge (1 = falling)
	input wire i_ext_clock_trigger_pin,
	input wire i_trigger_falling,
	// flag clear strobes
	input wire i_duty_flag_clear,
	input wire i_period_flag_clear,
	// status
	output wire o_run_control,
	output wire [CW-1:0] o_count,
	output wire o_duty_match_flag,
	output wire o_period_match_flag,
	// output pin
	output wire o_pin_out,
	output wire o_pin_out_en_n
);
	localparam [CW-1:0] CNT_ZERO = `PTM_CNT_ZERO;
	localparam [CW-1:0] CNT_ONE = `PTM_CNT_ONE;
	// run states are one-hot: stopped and running
	localparam [1:0] ST_STOP = `PTM_ST_STOP;
	localparam [1:0] ST_RUN = `PTM_ST_RUN;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [CW-1:0] cnt_r;
	reg [CW-1:0] cnt_nxt;
	reg duty_flag_r;
	reg period_flag_r;
	reg level_r;
	reg level_nxt;
	reg pin_r;
	reg pin_en_n_r;
	reg trig_dly_r;
	reg trig_fill1_r;
	reg trig_fill2_r;
	reg trig_arm_r;
	reg clr;

	wire trig_sync;
	wire run_r;
	wire run_nxt;
	wire run_rise;
	wire tick;
	wire [CW-1:0] cnt_inc;
	wire duty_hit;
	wire period_hit;
	wire trig_edge;
	wire trig_rise;
	wire trig_fall;
	wire m_cmp;
	wire m_cap;
	wire m_tmr;
	wire m_pwm_grp;
	wire m_single;
	wire m_pwm;
	wire cm_like;
	wire duty_set;
	wire period_set;
	wire pwm_full;
	wire pwm_on_nxt;

	// mode decode
	assign m_cmp = (i_mode_select == `PTM_MODE_CMP); // R1
	assign m_cap = (i_mode_select == `PTM_MODE_CAP);
	assign m_tmr = (i_mode_select == `PTM_MODE_TMR); // R1
	assign m_pwm_grp = (i_mode_select == `PTM_MODE_PWM); // R1
	assign m_single = m_pwm_grp & (i_pin_action == `PTM_PWM_SINGLE); // R16
	assign m_pwm = m_pwm_grp & ~m_single; // R9
	assign cm_like = m_cmp | m_tmr; // R8

	// trigger pin crosses in through two flops before edge detection
	ptm_sync #(
		.W(1)
	) u_trig_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_ext_clock_trigger_pin),
		.o_sync(trig_sync)
	);

	// edges are ignored until the delay stage holds a real pin sample, so reset gives no false edge
	always @(posedge i_clk) begin
		if (i_rst) begin
			trig_dly_r <= 1'b0;
			trig_fill1_r <= 1'b0;
			trig_fill2_r <= 1'b0;
			trig_arm_r <= 1'b0;
		end else begin
			trig_dly_r <= trig_sync;
			trig_fill1_r <= 1'b1;
			trig_fill2_r <= trig_fill1_r;
			trig_arm_r <= trig_fill2_r;
		end
	end

	// active edge picked by the trigger-edge select
	assign trig_rise = ~trig_dly_r & trig_sync;
	assign trig_fall = trig_dly_r & ~trig_sync;
	assign trig_edge = trig_arm_r & (i_trigger_falling ? trig_fall : trig_rise); // R17

	// counter steps only while running, unpaused and not restarting
	assign run_r = state_r[1];
	assign run_rise = run_nxt & ~run_r;
	assign tick = run_r & ~i_count_pause & ~run_rise;
	assign cnt_inc = cnt_r + CNT_ONE;

	// comparators look at the next count so the period spans exactly the value
	ptm_cmp #(
		.W(CW)
	) u_duty_cmp (
		.i_en(tick),
		.i_zero_ok(1'b0),
		.i_count(cnt_inc),
		.i_value(i_duty_compare_value),
		.o_hit(duty_hit)
	);

	// period value zero matches on wrap, which is the overflow at the top count
	ptm_cmp #(
		.W(CW)
	) u_period_cmp (
		.i_en(tick),
		.i_zero_ok(1'b1),
		.i_count(cnt_inc),
		.i_value(i_period_compare_value),
		.o_hit(period_hit)
	);

	// run control: software write wins over trigger, trigger over match stop
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_STOP: begin
			if (i_run_write) begin
				if (i_run_wdata) begin
					state_nxt = ST_RUN; // R17
				end
			end else if (m_single && trig_edge) begin
				state_nxt = ST_RUN; // R17
			end
		end
		// a trigger edge in the same cycle as the match keeps a running pulse alive
		ST_RUN: begin
			if (i_run_write) begin
				if (!i_run_wdata) begin
					state_nxt = ST_STOP; // R18
				end
			end else if (m_single && duty_hit && !trig_edge) begin
				state_nxt = ST_STOP; // R18
			end
		end
		// an illegal code falls back to stopped
		default: begin
			state_nxt = ST_STOP;
		end
		endcase
	end

	assign run_nxt = state_nxt[1];

	// counter clear source per mode
	always @* begin
		clr = 1'b0;
		if (cm_like) begin
			if (i_clear_select) begin
				clr = duty_hit; // R3
			end else begin
				clr = period_hit; // R2
			end
		end else if (m_pwm || m_cap) begin
			clr = period_hit; // R10
		end
	end

	// a duty value of zero never hits, so the count just wraps past the top
	always @* begin
		cnt_nxt = cnt_r;
		if (run_rise) begin
			cnt_nxt = CNT_ZERO; // R21
		end else if (tick) begin
			if (clr) begin
				cnt_nxt = CNT_ZERO; // R11
			end else begin
				cnt_nxt = cnt_inc; // R4
			end
		end
	end

	// single pulse never clears the count while running
	always @(posedge i_clk) begin
		if (i_rst) begin
			state_r <= ST_STOP;
			cnt_r <= CNT_ZERO;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt; // R19
		end
	end

	// flag sources; period flag is suppressed when the duty match clears
	assign duty_set = duty_hit & (cm_like | m_pwm_grp); // R13
	assign period_set = period_hit & ((cm_like & ~i_clear_select) | m_pwm | m_cap); // R3

	// set wins over a clear arriving in the same cycle
	always @(posedge i_clk) begin
		if (i_rst) begin
			duty_flag_r <= 1'b0;
			period_flag_r <= 1'b0;
		end else begin
			duty_flag_r <= duty_set | (duty_flag_r & ~i_duty_flag_clear); // R2
			period_flag_r <= period_set | (period_flag_r & ~i_period_flag_clear); // R13
		end
	end

	// PWM active while the count is below duty, or always when duty covers the period
	assign pwm_full = (|i_period_compare_value) & (i_duty_compare_value >= i_period_compare_value); // R12
	assign pwm_on_nxt = pwm_full | (cnt_nxt < i_duty_compare_value); // R11

	// output level before polarity
	always @* begin
		level_nxt = level_r;
		if (m_cmp) begin
			if (run_rise) begin
				level_nxt = i_output_control; // R7
			end else if (duty_hit) begin
				case (i_pin_action) // R5
				`PTM_ACT_LOW: begin
					level_nxt = 1'b0; // R6
				end
				`PTM_ACT_HIGH: begin
					level_nxt = 1'b1; // R6
				end
				`PTM_ACT_TOGGLE: begin
					level_nxt = ~level_r; // R6
				end
				default: begin
					level_nxt = level_r; // R6
				end
				endcase
			end
		end else if (m_pwm) begin
			case (i_pin_action) // R14
			`PTM_PWM_INACTIVE: begin
				level_nxt = ~i_output_control; // R15
			end
			`PTM_PWM_ACTIVE: begin
				level_nxt = i_output_control; // R15
			end
			default: begin
				level_nxt = pwm_on_nxt ? i_output_control : ~i_output_control; // R14
			end
			endcase
		end else if (m_single) begin
			level_nxt = run_nxt ? i_output_control : ~i_output_control; // R18
		end
	end

	// pin is released in timer and capture modes so it can serve other functions
	always @(posedge i_clk) begin
		if (i_rst) begin
			level_r <= 1'b0;
			pin_r <= 1'b0;
			pin_en_n_r <= 1'b1;
		end else begin
			level_r <= level_nxt;
			pin_r <= level_nxt ^ i_output_polarity; // R14
			pin_en_n_r <= m_tmr | m_cap; // R8
		end
	end

	// outputs
	assign o_run_control = run_r;
	assign o_count = cnt_r;
	assign o_duty_match_flag = duty_flag_r;
	assign o_period_match_flag = period_flag_r;
	assign o_pin_out = pin_r;
	assign o_pin_out_en_n = pin_en_n_r;
endmodule
`default_nettype wire

/* File: ptm_top_tb.sv */
// self-checking bench for the periodic timer
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("mismatch %0t %h %h", $time, a, b); end end
module ptm_top_tb;
	logic i_clk = 1'b0, i_rst = 1'b1, i_output_control = 1'b0, i_output_polarity = 1'b0, i_clear_select = 1'b0;
	logic i_count_pause = 1'b0, i_run_write = 1'b0, i_run_wdata = 1'b0, i_ext_clock_trigger_pin = 1'b0;
	logic i_trigger_falling = 1'b0, i_duty_flag_clear = 1'b0, i_period_flag_clear = 1'b0;
	logic [1:0] i_mode_select = 2'h0, i_pin_action = 2'h0;
	logic [9:0] i_duty_compare_value = 10'h000, i_period_compare_value = 10'h000;
	wire o_run_control, o_duty_match_flag, o_period_match_flag, o_pin_out, o_pin_out_en_n;
	wire [9:0] o_count;
	int n_fail = 0, cmp_count = 0, i;
	ptm_top uut (.i_clk, .i_rst, .i_mode_select, .i_pin_action, .i_output_control, .i_output_polarity,
		.i_clear_select, .i_count_pause, .i_run_write, .i_run_wdata, .i_duty_compare_value, .i_period_compare_value,
		.i_ext_clock_trigger_pin, .i_trigger_falling, .i_duty_flag_clear, .i_period_flag_clear, .o_run_control,
		.o_count, .o_duty_match_flag, .o_period_match_flag, .o_pin_out, .o_pin_out_en_n);
	always #20 i_clk = ~i_clk;
	task cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task wr(input logic v);
		i_run_write = 1'b1;
		i_run_wdata = v;
		cyc(1);
		i_run_write = 1'b0;
	endtask
	// controls only change while stopped, as unstable pwm output would follow otherwise
	task cfg(input logic [1:0] m, a, input logic oc, cs, input logic [9:0] d, p);
		wr(1'b0);
		i_mode_select = m;
		i_pin_action = a;
		i_output_control = oc;
		i_clear_select = cs;
		i_duty_compare_value = d;
		i_period_compare_value = p;
		i_duty_flag_clear = 1'b1;
		i_period_flag_clear = 1'b1;
		cyc(1);
		i_duty_flag_clear = 1'b0;
		i_period_flag_clear = 1'b0;
		cyc(1);
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#(40 * 8000);
		n_fail++;
		wrap_up;
	end
	initial begin
		cyc(4);
		i_rst = 1'b0;
		cfg(2'h0, 2'h3, 1'b0, 1'b0, 10'h002, 10'h003);
		wr(1'b1);
		`CK(o_count, 10'h000)
		`CK(o_pin_out_en_n, 1'b0)
		cyc(2);
		`CK(o_duty_match_flag, 1'b1)
		`CK(o_pin_out, 1'b1)
		cyc(1);
		`CK(o_count, 10'h000)
		`CK(o_period_match_flag, 1'b1)
		`CK(o_pin_out, 1'b1)
		for (i = 0; i < 8; i++) begin
			cfg(2'h0, i[1:0], i[2], 1'b0, 10'h003, 10'h008);
			wr(1'b1);
			cyc(3);
			`CK(o_pin_out, 1'(i[1:0] == 0 ? i[2] : i[1:0] == 3 ? !i[2] : i[1]))
		end
		cfg(2'h0, 2'h0, 1'b0, 1'b1, 10'h004, 10'h002);
		wr(1'b1);
		cyc(12);
		`CK(o_period_match_flag, 1'b0)
		`CK(o_duty_match_flag, 1'b1)
		`CK(o_count <= 10'h004, 1'b1)
		cfg(2'h3, 2'h3, 1'b0, 1'b0, 10'h002, 10'h003);
		wr(1'b1);
		cyc(3);
		`CK(o_pin_out_en_n, 1'b1)
		`CK(o_period_match_flag, 1'b1)
		// clear-select set on purpose: pwm must still wrap on the period
		cfg(2'h2, 2'h2, 1'b1, 1'b1, 10'h002, 10'h004);
		wr(1'b1);
		for (i = 0; i < 8; i++) begin
			`CK(o_count, 10'(i % 4))
			`CK(o_pin_out, 1'(i % 4 < 2))
			cyc(1);
		end
		`CK(o_period_match_flag & o_duty_match_flag, 1'b1)
		cfg(2'h2, 2'h2, 1'b1, 1'b0, 10'h005, 10'h004);
		wr(1'b1);
		cyc(6);
		`CK(o_pin_out, 1'b1)
		cfg(2'h2, 2'h0, 1'b1, 1'b0, 10'h002, 10'h004);
		i_output_polarity = 1'b1;
		wr(1'b1);
		cyc(5);
		`CK(o_pin_out, 1'b1)
		`CK(o_count, 10'h001)
		cfg(2'h2, 2'h2, 1'b1, 1'b0, 10'h200, 10'h000);
		i_output_polarity = 1'b0;
		wr(1'b1);
		cyc(1023);
		`CK(o_count, 10'h3ff)
		cyc(1);
		`CK(o_period_match_flag, 1'b1)
		cfg(2'h3, 2'h0, 1'b0, 1'b0, 10'h000, 10'h000);
		wr(1'b1);
		cyc(1024);
		`CK(o_count, 10'h000)
		`CK(o_duty_match_flag, 1'b0)
		cfg(2'h2, 2'h3, 1'b1, 1'b0, 10'h003, 10'h001);
		wr(1'b1);
		`CK(o_pin_out, 1'b1)
		cyc(7);
		`CK(o_run_control, 1'b0)
		`CK(o_count, 10'h003)
		i_ext_clock_trigger_pin = 1'b1;
		cyc(4);
		`CK(o_run_control, 1'b1)
		wr(1'b0);
		`CK(o_pin_out, 1'b0)
		// third pulse from a falling trigger edge, paused part way
		i_trigger_falling = 1'b1;
		i_ext_clock_trigger_pin = 1'b0;
		cyc(4);
		`CK(o_run_control, 1'b1)
		i_count_pause = 1'b1;
		cyc(3);
		`CK(o_count, 10'h001)
		`CK(o_pin_out, 1'b1)
		i_count_pause = 1'b0;
		cyc(3);
		`CK(o_run_control, 1'b0)
		`CK(o_count, 10'h003)
		`CK(o_pin_out, 1'b0)
		wrap_up;
	end
endmodule
`default_nettype wire
